// file: src/two_hand_type3_monitor.sv
// Two-hand type III monitor with Avalon-MM register slave and interrupt
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "thc_regs.svh"
module two_hand_type3_monitor #(
  parameter logic [31:0] SKEW_CYCLES = `SKEW_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic first_button_in_i,
  input wire logic second_button_in_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic dual_press_safe_out_o,
  output logic ready_o,
  output logic error_o,
  output logic [15:0] diagnostic_state_code_o,
  output logic irq_o
);
  import thc_pkg::*;

  thc_pkg::mon_state_t state_q;
  thc_pkg::mon_state_t state_d;
  logic [1:0] buttons_s;
  logic b1;
  logic b2;
  logic expired;
  logic act_q;
  logic act_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ready_q;
  logic err_q;
  logic out_q;
  logic [15:0] diag_q;
  logic irq_q;
  logic [`IRQ_WIDTH-1:0] irq_stat_q;
  logic [`IRQ_WIDTH-1:0] irq_stat_d;
  logic [`IRQ_WIDTH-1:0] irq_mask_q;
  logic [`IRQ_WIDTH-1:0] irq_mask_d;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic [15:0] diag_d;
  logic ready_d;
  logic err_d;
  logic out_d;

  // Buttons are asynchronous pins
  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({second_button_in_i, first_button_in_i}),
    .sync_o(buttons_s)
  );

  assign b1 = buttons_s[0];
  assign b2 = buttons_s[1];

  // Window restarts on every state change, so it measures time spent in one press state
  skew_timer #(
    .LIMIT_CYCLES(SKEW_CYCLES)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .restart_i(state_d != state_q),
    .expired_o(expired)
  );

  // Bus decode: one wait cycle, then a single answer cycle
  wire req = avs_read_i | avs_write_i;
  wire accept = req & wait_q;
  // Writes land on the edge where the master sees waitrequest low, never earlier
  wire bus_commit = req & ~wait_q;
  wire wr_ctrl = bus_commit & avs_write_i & (avs_address_i == `CTRL_OFFSET) & avs_byteenable_i[0];
  wire wr_stat = bus_commit & avs_write_i & (avs_address_i == `IRQ_STAT_OFFSET) & avs_byteenable_i[0];
  wire wr_mask = bus_commit & avs_write_i & (avs_address_i == `IRQ_MASK_OFFSET) & avs_byteenable_i[0];

  assign act_d = wr_ctrl ? avs_writedata_i[`CTRL_ACTIVATE_BIT] : act_q;

  wire [31:0] status_word = {diag_q, 13'h0, out_q, err_q, ready_q};
  wire [31:0] sel_data =
    (avs_address_i == `CTRL_OFFSET) ? {31'h0, act_q} :
    (avs_address_i == `STATUS_OFFSET) ? status_word :
    (avs_address_i == `IRQ_STAT_OFFSET) ? {29'h0, irq_stat_q} :
    (avs_address_i == `IRQ_MASK_OFFSET) ? {29'h0, irq_mask_q} : 32'h0;
  assign rdata_d = (accept & avs_read_i) ? sel_data : 32'h0;

  // Next state; the activate check comes first
  always_comb begin
    state_d = state_q;
    if (!act_q) begin
      state_d = st_idle;
    end else begin
      case (state_q)
        st_idle: begin
          state_d = st_init;
        end
        st_init: begin
          if (b1 && b2) begin
            state_d = st_err_act_both;
          end else if (b1) begin
            state_d = st_err_act_b1;
          end else if (b2) begin
            state_d = st_err_act_b2;
          end else begin
            state_d = st_both_off;
          end
        end
        st_both_off: begin
          if (b1 && b2) begin
            state_d = st_out_on;
          end else if (b1) begin
            state_d = st_b1_on;
          end else if (b2) begin
            state_d = st_b2_on;
          end else begin
            state_d = st_both_off;
          end
        end
        st_b1_on, st_b2_on: begin
          if (!b1 && !b2) begin
            state_d = st_both_off;
          end else if (expired) begin
            if (b1 && b2) begin
              state_d = st_err_skew_both;
            end else if (b1) begin
              state_d = st_err_skew_b1;
            end else begin
              state_d = st_err_skew_b2;
            end
          end else if (b1 && b2) begin
            state_d = st_out_on;
          end else if ((state_q == st_b1_on) ? b2 : b1) begin
            // First button let go while the second went on: wrong order
            state_d = st_locked_on;
          end else begin
            state_d = state_q;
          end
        end
        st_out_on: begin
          if (b1 && b2) begin
            state_d = st_out_on;
          end else if (b1) begin
            state_d = st_rel_b2;
          end else if (b2) begin
            state_d = st_rel_b1;
          end else begin
            state_d = st_both_off;
          end
        end
        st_rel_b2, st_rel_b1, st_locked_off: begin
          if (!b1 && !b2) begin
            state_d = st_both_off;
          end else if (b1 && b2) begin
            state_d = st_locked_off;
          end else if (b1) begin
            state_d = st_rel_b2;
          end else begin
            state_d = st_rel_b1;
          end
        end
        st_locked_on, st_err_act_b1, st_err_act_b2, st_err_act_both,
        st_err_skew_b2, st_err_skew_b1, st_err_skew_both: begin
          // Errors and lock-on leave only when both hands are off
          state_d = (!b1 && !b2) ? st_both_off : state_q;
        end
        default: begin
          state_d = st_idle;
        end
      endcase
    end
  end

  function automatic logic [15:0] code_of(input thc_pkg::mon_state_t s);
    case (s)
      st_idle: code_of = `CODE_IDLE;
      st_init: code_of = `CODE_INIT;
      st_both_off: code_of = `CODE_BOTH_OFF;
      st_b1_on: code_of = `CODE_B1_ON;
      st_b2_on: code_of = `CODE_B2_ON;
      st_out_on: code_of = `CODE_OUT_ON;
      st_rel_b2: code_of = `CODE_REL_B2;
      st_rel_b1: code_of = `CODE_REL_B1;
      st_locked_off: code_of = `CODE_LOCKED_OFF;
      st_locked_on: code_of = `CODE_LOCKED_ON;
      st_err_act_b1: code_of = `CODE_ACT_B1;
      st_err_act_b2: code_of = `CODE_ACT_B2;
      st_err_act_both: code_of = `CODE_ACT_BOTH;
      st_err_skew_b2: code_of = `CODE_SKEW_B2;
      st_err_skew_b1: code_of = `CODE_SKEW_B1;
      st_err_skew_both: code_of = `CODE_SKEW_BOTH;
      default: code_of = `CODE_IDLE;
    endcase
  endfunction : code_of

  // Outputs follow the next state so they stand in step with state_q
  assign diag_d = code_of(state_d);
  assign ready_d = (state_d != st_idle);
  assign err_d = (diag_d[15:12] == 4'hC);
  assign out_d = (state_d == st_out_on) && !err_d;

  assign irq_event[`IRQ_OUT_ON_BIT] = out_d & ~out_q;
  assign irq_event[`IRQ_OUT_OFF_BIT] = ~out_d & out_q;
  assign irq_event[`IRQ_ERROR_BIT] = err_d & ~err_q;
  // A new event wins over a write-one-to-clear in the same cycle
  assign irq_stat_d = (irq_stat_q & ~(wr_stat ? avs_writedata_i[`IRQ_WIDTH-1:0] : `IRQ_RESET)) | irq_event;
  assign irq_mask_d = wr_mask ? avs_writedata_i[`IRQ_WIDTH-1:0] : irq_mask_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q <= st_idle;
      act_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      diag_q <= `CODE_IDLE;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      out_q <= 1'b0;
      irq_stat_q <= `IRQ_RESET;
      irq_mask_q <= `IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      act_q <= act_d;
      wait_q <= ~accept;
      rdata_q <= rdata_d;
      diag_q <= diag_d;
      ready_q <= ready_d;
      err_q <= err_d;
      out_q <= out_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= |(irq_stat_d & irq_mask_d);
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign dual_press_safe_out_o = out_q;
  assign ready_o = ready_q;
  assign error_o = err_q;
  assign diagnostic_state_code_o = diag_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  idle_priority_a: assert property (!act_q |=> (diag_q == `CODE_IDLE) && !out_q)
    else $error("activate low did not force idle");
  out_cause_a: assert property ($rose(out_q) |-> $past(b1 && b2)
    && ($past(state_q) inside {st_both_off, st_b1_on, st_b2_on}) && !err_q)
    else $error("safe output rose without a valid two-hand press");
  rearm_release_a: assert property ($fell(out_q) && act_q && (state_q inside {st_rel_b2, st_rel_b1}) |=> !out_q)
    else $error("safe output re-armed without release");
  act_error_a: assert property ((state_q == st_init) && act_q && b1 && !b2
    |=> (diag_q == `CODE_ACT_B1) && ready_q && err_q && !out_q)
    else $error("activation with button one pressed not flagged");
  skew_error_a: assert property ((state_q == st_b1_on) && act_q && expired && b1 && !b2
    |=> (diag_q == `CODE_SKEW_B1) && err_q)
    else $error("skew timeout in button one state not flagged");

  // Diagnostic code checks for the remaining activation and skew errors, then lock-on, error, bus and reset checks
  act_b2_a: assert property ((state_q == st_init) && act_q && !b1 && b2
    |=> (diag_q == `CODE_ACT_B2) && ready_q && err_q && !out_q)
    else $error("activation with button two pressed not flagged");
  act_both_a: assert property ((state_q == st_init) && act_q && b1 && b2
    |=> (diag_q == `CODE_ACT_BOTH) && ready_q && err_q && !out_q)
    else $error("activation with both buttons pressed not flagged");
  skew_b2_a: assert property ((state_q == st_b2_on) && act_q && expired && !b1 && b2
    |=> (diag_q == `CODE_SKEW_B2) && ready_q && err_q)
    else $error("skew timeout in button two state not flagged");
  skew_both_a: assert property ((state_q inside {st_b1_on, st_b2_on}) && act_q && expired && b1 && b2
    |=> (diag_q == `CODE_SKEW_BOTH) && ready_q && err_q && !out_q)
    else $error("skew timeout with both buttons on not flagged");
  wrong_order_a: assert property ((state_q == st_b1_on) && act_q && !expired && !b1 && b2
    |=> (diag_q == `CODE_LOCKED_ON))
    else $error("wrong press order not locked on");
  error_ready_a: assert property (err_q |-> ready_q)
    else $error("error raised without ready");
  ctrl_write_a: assert property (wr_ctrl
    |=> act_q == $past(avs_writedata_i[`CTRL_ACTIVATE_BIT]))
    else $error("control write did not land");
  idle_data_a: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
    else $error("read data not zero outside the answer cycle");
  error_safe_a: assert property (err_q |-> !out_q)
    else $error("safe output high during error");
  error_clear_a: assert property (err_q && act_q && !b1 && !b2 |=> !err_q && (diag_q == `CODE_BOTH_OFF))
    else $error("error not cleared on release of both buttons");
  locked_on_a: assert property ((diag_q == `CODE_LOCKED_ON) |-> ready_q && !err_q && !out_q)
    else $error("locked-on outputs wrong");
  idle_outputs_a: assert property ((diag_q == `CODE_IDLE) |-> !ready_q && !err_q && !out_q)
    else $error("idle outputs wrong");
  reset_default_a: assert property (disable iff (1'b0) reset_i
    |=> (diag_q == `CODE_IDLE) && !ready_q && !err_q && !out_q && !irq_q && avs_waitrequest_o)
    else $error("outputs not at defaults after reset");
  bus_answer_a: assert property (req && wait_q |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not a single cycle");

endmodule : two_hand_type3_monitor

// file: src/thc_regs.svh
// Register map, field positions, diagnostic codes and timing counts of the two-hand monitor
// Function
// - A low activate bit sends the monitor to idle from any state, ahead of every other transition.
// - Each button input is one boolean, low meaning released and high meaning pressed, low by default.
// - The safe output goes high only after both buttons came on in the right order within 500 ms with no error.
// - Once the safe output has dropped, both buttons must be released before it may rise again.
// - A button already pressed when the monitor is activated is an illegal input and leads to an error state.
// - A skew of more than 500 ms between the two buttons coming on leads to an error state.
// - In every error state the safe output is held low.
// - An error clears only when both buttons are released at the same time; the code clears it once both read released, in either order.
// - Activation errors report C001 for button one only, C002 for button two only, C003 for both, with ready and error high and output low.
// - The 16-bit diagnostic code resets to zero and ready, error and safe output all reset low.
// - In idle the code is 0000 with ready, error and safe output all low.
// - After a wrong press order without a fault the code is 8019, ready high, error low, output low, waiting for release.
// - Skew expiry with only button two, only button one, or both on reports C004, C005 or C006 with error high.
`ifndef THC_REGS_SVH
`define THC_REGS_SVH

`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define IRQ_STAT_OFFSET 4'h8
`define IRQ_MASK_OFFSET 4'hC

`define CTRL_ACTIVATE_BIT 0
`define STATUS_READY_BIT 0
`define STATUS_ERROR_BIT 1
`define STATUS_OUT_BIT 2
`define STATUS_CODE_LSB 16
`define IRQ_OUT_ON_BIT 0
`define IRQ_OUT_OFF_BIT 1
`define IRQ_ERROR_BIT 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0

`define CODE_IDLE 16'h0000
`define CODE_INIT 16'h8001
`define CODE_OUT_ON 16'h8000
`define CODE_BOTH_OFF 16'h8004
`define CODE_B1_ON 16'h8005
`define CODE_B2_ON 16'h8006
`define CODE_REL_B2 16'h8007
`define CODE_REL_B1 16'h8008
`define CODE_LOCKED_OFF 16'h8009
`define CODE_LOCKED_ON 16'h8019
`define CODE_ACT_B1 16'hC001
`define CODE_ACT_B2 16'hC002
`define CODE_ACT_BOTH 16'hC003
`define CODE_SKEW_B2 16'hC004
`define CODE_SKEW_B1 16'hC005
`define CODE_SKEW_BOTH 16'hC006

`define CLK_PERIOD_NS 20
`define SKEW_TIME_MS 500
`define SKEW_CYCLES ((`SKEW_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// file: src/thc_pkg.sv
// Types shared by the two-hand monitor files
package thc_pkg;

  typedef enum logic [3:0] {
    st_idle = 4'h0,
    st_init = 4'h1,
    st_both_off = 4'h2,
    st_b1_on = 4'h3,
    st_b2_on = 4'h4,
    st_out_on = 4'h5,
    st_rel_b2 = 4'h6,
    st_rel_b1 = 4'h7,
    st_locked_off = 4'h8,
    st_locked_on = 4'h9,
    st_err_act_b1 = 4'hA,
    st_err_act_b2 = 4'hB,
    st_err_act_both = 4'hC,
    st_err_skew_b2 = 4'hD,
    st_err_skew_b1 = 4'hE,
    st_err_skew_both = 4'hF
  } mon_state_t;

endpackage : thc_pkg

// file: src/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic stable_q;
      // Released buttons are the safe default, so both stages reset low
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= async_i[g];
          stable_q <= meta_q;
        end
      end
      assign sync_o[g] = stable_q;
    end
  endgenerate
endmodule : pin_sync

// file: src/skew_timer.sv
// Saturating cycle counter that flags when the press skew window has run out
`timescale 1ns/100ps
module skew_timer #(
  parameter logic [31:0] LIMIT_CYCLES = 32'd25000000
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic restart_i,
  output logic expired_o
);
  logic [31:0] count_q;
  logic [31:0] count_d;
  wire at_limit = (count_q >= LIMIT_CYCLES);

  // Saturates so a long hold never wraps back into the window
  assign count_d = restart_i ? 32'h0 : (at_limit ? count_q : count_q + 32'h1);
  assign expired_o = at_limit;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      count_q <= 32'h0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : skew_timer

// file: test/button_pair_model.sv
// Behavioural pair of operator push buttons facing the monitor
`timescale 1ns/100ps
module button_pair_model (
  input wire logic sys_clk_i,
  input wire logic first_press_i,
  input wire logic second_press_i,
  output logic first_button_o = 1'b0,
  output logic second_button_o = 1'b0
);
  // Contacts give real levels; a released button reads low and never floats
  always @(posedge sys_clk_i) begin
    first_button_o <= first_press_i;
    second_button_o <= second_press_i;
  end
endmodule : button_pair_model

// file: test/two_hand_type3_monitor_tb.sv
// Self-checking bench for the two-hand type III monitor
`timescale 1ns/100ps
`include "thc_regs.svh"
module two_hand_type3_monitor_tb;
  localparam int SKEW = 50;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic b1_cmd = 1'b0;
  logic b2_cmd = 1'b0;
  logic b1_pin;
  logic b2_pin;
  logic [3:0] address = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] byte_en = 4'hF;
  logic [31:0] rdata;
  logic wreq;
  logic safe;
  logic rdy;
  logic err;
  logic [15:0] code;
  logic irq;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  button_pair_model i_btn (
    .sys_clk_i(sys_clk_i),
    .first_press_i(b1_cmd),
    .second_press_i(b2_cmd),
    .first_button_o(b1_pin),
    .second_button_o(b2_pin)
  );

  // Short skew window keeps the expiry runs brief
  two_hand_type3_monitor #(.SKEW_CYCLES(32'd50)) i_dut (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .first_button_in_i(b1_pin),
    .second_button_in_i(b2_pin),
    .avs_address_i(address),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdata),
    .avs_byteenable_i(byte_en),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq),
    .dual_press_safe_out_o(safe),
    .ready_o(rdy),
    .error_o(err),
    .diagnostic_state_code_o(code),
    .irq_o(irq)
  );

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task cw(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cw

  // Request held until waitrequest is sampled low; data taken at that edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    address <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    // The wait ends when waitrequest reads low; the bench timeout catches a hang
    do begin
      @(posedge sys_clk_i);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : reg_wr

  task reg_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : reg_rd

  task chk_st(input logic [15:0] c, input logic r, input logic e, input logic o);
    chk("code", {16'h0, c}, {16'h0, code});
    chk("ready", {31'h0, r}, {31'h0, rdy});
    chk("error", {31'h0, e}, {31'h0, err});
    chk("out", {31'h0, o}, {31'h0, safe});
  endtask : chk_st

  // Pin change reaches the outputs four edges later: button model flop, two synchroniser flops and the output register
  task press(input logic a, input logic b);
    b1_cmd <= a;
    b2_cmd <= b;
    cw(6);
  endtask : press

  task act(input logic on);
    reg_wr(`CTRL_OFFSET, {31'h0, on});
    cw(3);
  endtask : act

  task t_reset;
    chk_st(`CODE_IDLE, 1'b0, 1'b0, 1'b0);
    reg_rd(`STATUS_OFFSET, 32'h0, "status");
    reg_rd(4'h2, 32'h0, "unmapped");
    byte_en <= 4'h0;
    reg_wr(`CTRL_OFFSET, 32'h1);
    byte_en <= 4'hF;
    reg_rd(`CTRL_OFFSET, 32'h0, "ctrl no lane");
    chk_st(`CODE_IDLE, 1'b0, 1'b0, 1'b0);
    press(1'b1, 1'b0);
    chk_st(`CODE_IDLE, 1'b0, 1'b0, 1'b0);
    press(1'b0, 1'b0);
  endtask : t_reset

  task t_act_err;
    logic [1:0] i;
    for (int k = 1; k < 4; k++) begin
      i = 2'(k);
      press(i[0], i[1]);
      act(1'b1);
      chk_st(16'hC000 | {14'h0, i}, 1'b1, 1'b1, 1'b0);
      press(1'b0, 1'b0);
      chk_st(`CODE_BOTH_OFF, 1'b1, 1'b0, 1'b0);
      act(1'b0);
      chk_st(`CODE_IDLE, 1'b0, 1'b0, 1'b0);
    end
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask : t_act_err

  task t_good;
    reg_wr(`IRQ_STAT_OFFSET, 32'h7);
    act(1'b1);
    reg_rd(`CTRL_OFFSET, 32'h1, "ctrl");
    reg_rd(`IRQ_MASK_OFFSET, 32'h1, "irq_mask");
    press(1'b1, 1'b0);
    chk_st(`CODE_B1_ON, 1'b1, 1'b0, 1'b0);
    press(1'b1, 1'b1);
    chk_st(`CODE_OUT_ON, 1'b1, 1'b0, 1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    reg_rd(`IRQ_STAT_OFFSET, 32'h1, "irq_stat");
    reg_wr(`IRQ_STAT_OFFSET, 32'h1);
    cw(2);
    chk("irq clr", 32'h0, {31'h0, irq});
    reg_rd(`STATUS_OFFSET, 32'h8000_0005, "status");
    press(1'b1, 1'b0);
    chk_st(`CODE_REL_B2, 1'b1, 1'b0, 1'b0);
    reg_rd(`IRQ_STAT_OFFSET, 32'h2, "irq_stat fall");
    press(1'b1, 1'b1);
    chk_st(`CODE_LOCKED_OFF, 1'b1, 1'b0, 1'b0);
    press(1'b0, 1'b0);
    chk_st(`CODE_BOTH_OFF, 1'b1, 1'b0, 1'b0);
    press(1'b0, 1'b1);
    cw(SKEW - 20);
    press(1'b1, 1'b1);
    chk_st(`CODE_OUT_ON, 1'b1, 1'b0, 1'b1);
    act(1'b0);
    chk_st(`CODE_IDLE, 1'b0, 1'b0, 1'b0);
    press(1'b0, 1'b0);
  endtask : t_good

  task t_skew;
    act(1'b1);
    press(1'b1, 1'b0);
    cw(SKEW + 10);
    chk_st(`CODE_SKEW_B1, 1'b1, 1'b1, 1'b0);
    press(1'b0, 1'b0);
    chk_st(`CODE_BOTH_OFF, 1'b1, 1'b0, 1'b0);
    press(1'b0, 1'b1);
    cw(SKEW + 10);
    chk_st(`CODE_SKEW_B2, 1'b1, 1'b1, 1'b0);
    press(1'b1, 1'b1);
    chk_st(`CODE_SKEW_B2, 1'b1, 1'b1, 1'b0);
    press(1'b0, 1'b0);
    chk_st(`CODE_BOTH_OFF, 1'b1, 1'b0, 1'b0);
    act(1'b0);
  endtask : t_skew

  // Wrong order locks on; the both-on skew case needs button two to land on the expiry cycle
  task t_locked;
    reg_wr(`IRQ_MASK_OFFSET, 32'h4);
    cw(2);
    chk("irq err", 32'h1, {31'h0, irq});
    reg_rd(`IRQ_MASK_OFFSET, 32'h4, "irq_mask err");
    reg_wr(`IRQ_STAT_OFFSET, 32'h4);
    cw(2);
    chk("irq err clr", 32'h0, {31'h0, irq});
    act(1'b1);
    press(1'b1, 1'b0);
    press(1'b0, 1'b1);
    chk_st(`CODE_LOCKED_ON, 1'b1, 1'b0, 1'b0);
    press(1'b1, 1'b1);
    chk_st(`CODE_LOCKED_ON, 1'b1, 1'b0, 1'b0);
    press(1'b0, 1'b0);
    chk_st(`CODE_BOTH_OFF, 1'b1, 1'b0, 1'b0);
    press(1'b1, 1'b0);
    cw(SKEW - 5);
    press(1'b1, 1'b1);
    chk_st(`CODE_SKEW_BOTH, 1'b1, 1'b1, 1'b0);
    press(1'b0, 1'b0);
    chk_st(`CODE_BOTH_OFF, 1'b1, 1'b0, 1'b0);
    act(1'b0);
    chk_st(`CODE_IDLE, 1'b0, 1'b0, 1'b0);
  endtask : t_locked

  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    reg_wr(`IRQ_MASK_OFFSET, 32'h1);
    t_act_err();
    t_good();
    t_skew();
    t_locked();
    give_verdict();
  end
endmodule : two_hand_type3_monitor_tb
